// ---- hdl/tmr_pkg.sv ----
/*
 * Shared constants for the capture/compare/PWM timer: widths, channel
 * count, mode codes, dead-time counter width and synchroniser depth.
 * Assumes one clock domain; all users import the whole package.
 */
package tmr_pkg;
    localparam int CNT_WIDTH_DEF = 16;
    localparam int NUM_CH_DEF = 3;
    localparam int DT_WIDTH = 8;
    localparam int MODE_WIDTH = 2;
    localparam logic [MODE_WIDTH-1:0] MODE_OFF = 2'h0;
    localparam logic [MODE_WIDTH-1:0] MODE_CAPTURE = 2'h1;
    localparam logic [MODE_WIDTH-1:0] MODE_COMPARE = 2'h2;
    localparam logic [MODE_WIDTH-1:0] MODE_PWM = 2'h3;
    localparam int SYNC_STAGES = 3;
endpackage

// ---- hdl/tmr_deadtime.sv ----
/*
 * Dead-time generator for one complementary PWM pair.
 * Assumes pwm_in is a clean same-clock level and dt_cycles is stable.
 */
`timescale 1ns/1ns
module tmr_deadtime
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic pwm_in,
    input wire logic [DT_WIDTH-1:0] dt_cycles,
    output logic out_hi,
    output logic out_lo
);
    logic [DT_WIDTH-1:0] dt_cnt_reg;
    logic prev_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
            dt_cnt_reg <= '0;
        end else begin
            prev_reg <= pwm_in;
            if (pwm_in != prev_reg) begin
                dt_cnt_reg <= dt_cycles;
            end else if (dt_cnt_reg != '0) begin
                dt_cnt_reg <= dt_cnt_reg - 1'b1;
            end
        end
    end

    // Both legs low while the gap runs, so the pair never overlaps
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_hi <= 1'b0;
            out_lo <= 1'b0;
        end else if (!enable) begin
            out_hi <= pwm_in;
            out_lo <= ~pwm_in;
        end else begin
            out_hi <= pwm_in && prev_reg && (dt_cnt_reg == '0);
            out_lo <= !pwm_in && !prev_reg && (dt_cnt_reg == '0);
        end
    end

    property p_no_overlap;
        @(posedge clk) disable iff (!nrst)
        enable |-> !(out_hi && out_lo);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("dead-time legs overlap");

    property p_gap_start;
        @(posedge clk) disable iff (!nrst)
        (enable && (pwm_in != prev_reg)) |=> (!out_hi && !out_lo);
    endproperty
    a_gap_start: assert property (p_gap_start) else $error("dead time not started");
endmodule

// ---- hdl/tmr_core.sv ----
/*
 * Timer/counter with capture, compare and PWM channels, event counting,
 * trigger outputs toward the event routing network and optional dead time.
 * Assumes configuration inputs are static-ish levels on clk; event and
 * capture inputs may come from pins and are synchronised here.
 */
// How it works
// - One counter per instance, its width set by CNT_WIDTH to 16 or 32.
// - Up to three channels, each set on its own to capture, compare or PWM.
// - In capture mode the counter value is stored on the selected input edge.
// - In compare mode the channel output shows whether counter is below threshold.
// - In PWM mode the output follows the compare value, reloaded each period.
// - Where enabled, a dead time is put between complementary PWM edges.
// - The counter can count external events and emits routing triggers.
`timescale 1ns/1ns
module tmr_core
    import tmr_pkg::*;
#(
    parameter int CNT_WIDTH = CNT_WIDTH_DEF,
    parameter int NUM_CH = NUM_CH_DEF,
    parameter bit HAS_DEADTIME = 1'b1
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic count_events,
    input wire logic event_in,
    input wire logic [CNT_WIDTH-1:0] top_value,
    input wire logic [NUM_CH*MODE_WIDTH-1:0] ch_mode,
    input wire logic [NUM_CH-1:0] cap_falling,
    input wire logic [NUM_CH-1:0] cap_in,
    input wire logic [NUM_CH*CNT_WIDTH-1:0] cmp_wdata,
    input wire logic [NUM_CH-1:0] cmp_we,
    input wire logic dt_enable,
    input wire logic [DT_WIDTH-1:0] dt_cycles,
    input wire logic ovf_clear,
    output logic [CNT_WIDTH-1:0] count,
    output logic ovf_flag,
    output logic [NUM_CH*CNT_WIDTH-1:0] cap_value,
    output logic [NUM_CH-1:0] cap_valid,
    output logic [NUM_CH-1:0] ch_out,
    output logic [NUM_CH-1:0] ch_out_n,
    output logic ovf_trig,
    output logic [NUM_CH-1:0] ch_trig
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam int NS = NUM_CH + 1;
    logic [SYNC_STAGES-1:0] sync_reg [NS];
    logic [NS-1:0] level_reg;
    logic [NS-1:0] rise;
    logic [NS-1:0] fall;
    logic [NS-1:0] raw_in;

    assign raw_in = {event_in, cap_in};

    // Stage 0 only feeds stage 1; change taken once stages 1 and 2 agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NS; i++) begin
                sync_reg[i] <= '0;
            end
            level_reg <= '0;
        end else begin
            for (int i = 0; i < NS; i++) begin
                sync_reg[i] <= {sync_reg[i][SYNC_STAGES-2:0], raw_in[i]};
                if (sync_reg[i][1] == sync_reg[i][2]) begin
                    level_reg[i] <= sync_reg[i][2];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NS; i++) begin
            rise[i] = (sync_reg[i][1] == sync_reg[i][2]) && sync_reg[i][2] && !level_reg[i];
            fall[i] = (sync_reg[i][1] == sync_reg[i][2]) && !sync_reg[i][2] && level_reg[i];
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    logic tick;
    logic wrap;
    assign tick = run && (count_events ? rise[NUM_CH] : 1'b1);
    assign wrap = tick && (count >= top_value);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (tick) begin
            count <= wrap ? '0 : count + 1'b1;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovf_flag <= 1'b0;
        end else if (wrap) begin
            ovf_flag <= 1'b1;
        end else if (ovf_clear) begin
            ovf_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovf_trig <= 1'b0;
        end else begin
            ovf_trig <= wrap;
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    function automatic logic [MODE_WIDTH-1:0] mode_of(input int ch,
            input logic [NUM_CH*MODE_WIDTH-1:0] m);
        mode_of = m[ch*MODE_WIDTH +: MODE_WIDTH];
    endfunction

    logic [CNT_WIDTH-1:0] cmp_reg [NUM_CH];
    logic [CNT_WIDTH-1:0] buf_reg [NUM_CH];
    logic [NUM_CH-1:0] wave_reg;
    logic [NUM_CH-1:0] match;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            match[c] = (count == cmp_reg[c]);
        end
    end

    // PWM takes the written value only at wrap, so each period is clean
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cmp_reg[c] <= '0;
                buf_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (cmp_we[c]) begin
                    buf_reg[c] <= cmp_wdata[c*CNT_WIDTH +: CNT_WIDTH];
                end
                if (mode_of(c, ch_mode) != MODE_PWM && cmp_we[c]) begin
                    cmp_reg[c] <= cmp_wdata[c*CNT_WIDTH +: CNT_WIDTH];
                end else if (mode_of(c, ch_mode) == MODE_PWM && wrap) begin
                    cmp_reg[c] <= buf_reg[c];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cap_value <= '0;
            cap_valid <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                cap_valid[c] <= 1'b0;
                if (mode_of(c, ch_mode) == MODE_CAPTURE &&
                        (cap_falling[c] ? fall[c] : rise[c])) begin
                    cap_value[c*CNT_WIDTH +: CNT_WIDTH] <= count;
                    cap_valid[c] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wave_reg <= '0;
            ch_trig <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                case (mode_of(c, ch_mode))
                    MODE_COMPARE: wave_reg[c] <= (count < cmp_reg[c]);
                    MODE_PWM: wave_reg[c] <= (count < cmp_reg[c]);
                    default: wave_reg[c] <= 1'b0;
                endcase
                ch_trig[c] <= (mode_of(c, ch_mode) == MODE_CAPTURE) ?
                    (cap_falling[c] ? fall[c] : rise[c]) :
                    (mode_of(c, ch_mode) != MODE_OFF && match[c]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs with optional dead time
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        if (HAS_DEADTIME) begin : g_dt
            tmr_deadtime u_dt (
                .clk(clk),
                .nrst(nrst),
                .enable(dt_enable),
                .pwm_in(wave_reg[g]),
                .dt_cycles(dt_cycles),
                .out_hi(ch_out[g]),
                .out_lo(ch_out_n[g])
            );
        end else begin : g_nodt
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ch_out[g] <= 1'b0;
                    ch_out_n[g] <= 1'b0;
                end else begin
                    ch_out[g] <= wave_reg[g];
                    ch_out_n[g] <= ~wave_reg[g];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_wrap_zero;
        @(posedge clk) disable iff (!nrst)
        wrap |=> (count == '0);
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not wrap");

    property p_step;
        @(posedge clk) disable iff (!nrst)
        (tick && !wrap) |=> (count == $past(count) + 1'b1);
    endproperty
    a_step: assert property (p_step) else $error("counter did not step");

    property p_hold;
        @(posedge clk) disable iff (!nrst)
        !tick |=> $stable(count);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved without tick");

    property p_ovf_set;
        @(posedge clk) disable iff (!nrst)
        wrap |=> ovf_flag;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_ovf_clr;
        @(posedge clk) disable iff (!nrst)
        (ovf_clear && !wrap) |=> !ovf_flag;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag not cleared");

    property p_ovf_trig;
        @(posedge clk) disable iff (!nrst)
        wrap |=> ovf_trig;
    endproperty
    a_ovf_trig: assert property (p_ovf_trig) else $error("overflow trigger missing");

    property p_cap;
        @(posedge clk) disable iff (!nrst)
        (mode_of(NUM_CH-1, ch_mode) == MODE_CAPTURE &&
            (cap_falling[NUM_CH-1] ? fall[NUM_CH-1] : rise[NUM_CH-1]))
            |=> cap_valid[NUM_CH-1] &&
            cap_value[NUM_CH*CNT_WIDTH-1 -: CNT_WIDTH] == $past(count);
    endproperty
    a_cap: assert property (p_cap) else $error("capture value wrong");

    property p_cmp;
        @(posedge clk) disable iff (!nrst)
        (mode_of(0, ch_mode) == MODE_COMPARE) |=> wave_reg[0] == ($past(count) < $past(cmp_reg[0]));
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare output wrong");

    property p_pwm_reload;
        @(posedge clk) disable iff (!nrst)
        (mode_of(0, ch_mode) == MODE_PWM && wrap) |=> cmp_reg[0] == $past(buf_reg[0]);
    endproperty
    a_pwm_reload: assert property (p_pwm_reload) else $error("PWM reload missed");

    property p_off_low;
        @(posedge clk) disable iff (!nrst)
        (mode_of(0, ch_mode) == MODE_OFF) |=> !wave_reg[0];
    endproperty
    a_off_low: assert property (p_off_low) else $error("idle channel active");
endmodule

// ---- dv/tmr_pin_source.sv ----
/*
 * Far-side pin model: drives the event pin and the capture pins.
 * Assumes the bench calls its tasks from one process on clk.
 */
`timescale 1ns/1ns
module tmr_pin_source
(
    input wire logic clk,
    output logic event_in,
    output logic [2:0] cap_in
);
    initial begin
        event_in = 1'b0;
        cap_in = 3'h0;
    end
    // Held 4 cycles each way so the 3-stage synchroniser never misses one
    task automatic ev_pulse();
        repeat (4) @(posedge clk);
        event_in <= 1'b1;
        repeat (4) @(posedge clk);
        event_in <= 1'b0;
    endtask
    task automatic cap_set(input int ch, input logic v);
        @(posedge clk);
        cap_in[ch] <= v;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ---- dv/test_timer_capture_compare_pwm.sv ----
/*
 * Self-checking bench for tmr_core with a behavioural counter model.
 * Assumes tmr_core defaults: 16-bit counter, 3 channels, dead time built.
 */
`timescale 1ns/1ns
module test_timer_capture_compare_pwm
    import tmr_pkg::*;
;
    logic clk, nrst, run, count_events, dt_enable, ovf_clear, event_in;
    logic [15:0] top_value, count;
    logic [5:0] ch_mode;
    logic [2:0] cap_falling, cap_in, cmp_we, cap_valid, ch_out, ch_out_n, ch_trig;
    logic [47:0] cmp_wdata, cap_value;
    logic [7:0] dt_cycles;
    logic ovf_flag, ovf_trig;
    int fails = 0, n_compared = 0;
    int m_cnt, m_act0, m_act1, m_pend1, m_wraps, n_ovf, n_cap, gap, seen_hi;
    int top, c0, c1, n, dt, k, seed;
    int m_last, cap_exp, n_trig;
    logic [1:0] h0, h1;
    logic [15:0] cap_seen;
    bit chk_cnt, chk_cmp, chk_dt;

    tmr_core DUT (.clk(clk), .nrst(nrst), .run(run), .count_events(count_events),
        .event_in(event_in), .top_value(top_value), .ch_mode(ch_mode),
        .cap_falling(cap_falling), .cap_in(cap_in), .cmp_wdata(cmp_wdata),
        .cmp_we(cmp_we), .dt_enable(dt_enable), .dt_cycles(dt_cycles),
        .ovf_clear(ovf_clear), .count(count), .ovf_flag(ovf_flag),
        .cap_value(cap_value), .cap_valid(cap_valid), .ch_out(ch_out),
        .ch_out_n(ch_out_n), .ovf_trig(ovf_trig), .ch_trig(ch_trig));
    tmr_pin_source src (.clk(clk), .event_in(event_in), .cap_in(cap_in));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // Reference model, free-running count only
    // ----------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {m_cnt, m_act0, m_act1, m_pend1, m_wraps} = '0;
        end else begin
            if (run && !count_events) begin
                if (m_cnt >= top_value) begin
                    m_cnt = 0;
                    m_act1 = m_pend1;
                    m_wraps++;
                end else begin
                    m_cnt++;
                end
            end
            if (cmp_we[1]) m_pend1 = cmp_wdata[31:16];
            if (cmp_we[0]) m_act0 = cmp_wdata[15:0];
        end
    end

    // ----------------------------------------
    // Monitors, sampled mid-cycle
    // ----------------------------------------
    always @(negedge clk) begin
        if (chk_cnt) check("count", 16'(m_cnt), count);
        if (chk_cmp) check("ch_out0", {15'h0, h0[1]}, {15'h0, ch_out[0]});
        if (chk_cmp) check("ch_out1", {15'h0, h1[1]}, {15'h0, ch_out[1]});
        if (chk_cmp) check("ch_out_n1", {15'h0, ~h1[1]}, {15'h0, ch_out_n[1]});
        if (chk_cmp) check("ch_out_n0", {15'h0, ~h0[1]}, {15'h0, ch_out_n[0]});
        if (chk_cmp) check("ch_out2", 16'h0, {14'h0, ch_out[2], ~ch_out_n[2]});
        h0 = {h0[0], m_cnt < m_act0};
        h1 = {h1[0], m_cnt < m_act1};
        if (ovf_trig === 1'b1) n_ovf++;
        if (cap_valid[2] === 1'b1) begin
            n_cap++;
            cap_seen = cap_value[47:32];
            cap_exp = m_last;
        end
        if (ch_trig[2] === 1'b1) n_trig++;
        m_last = m_cnt;
        if (chk_dt) begin
            if (ch_out[1] === 1'b1 && ch_out_n[1] === 1'b1) check("overlap", 16'h0, 16'h1);
            if ((ch_out[1] | ch_out_n[1]) === 1'b1) begin
                if (gap > 0 && seen_hi > 0) check("dead_gap", 16'(dt + 1), 16'(gap));
                gap = 0;
                seen_hi = 1;
            end else begin
                gap++;
            end
        end else begin
            gap = 0;
            seen_hi = 0;
        end
    end

    initial begin
        #(4 * 20000);
        fails++;
        summarize();
    end

    initial begin
        {nrst, run, count_events, dt_enable, ovf_clear, cap_falling, cmp_we} = '0;
        {top_value, ch_mode, cmp_wdata, dt_cycles, n_ovf, n_cap, h0, h1} = '0;
        seed = $urandom(32'hB4B1);
        repeat (3) @(posedge clk);
        check("rst_count", 16'h0, count);
        nrst <= 1'b1;
        // Free count, compare on ch0 and PWM on ch1 at once
        top = 8 + $urandom % 8;
        c0 = 1 + $urandom % top;
        c1 = 1 + $urandom % top;
        @(posedge clk);
        ch_mode <= {MODE_CAPTURE, MODE_PWM, MODE_COMPARE};
        top_value <= 16'(top);
        cmp_wdata <= {16'h0, 16'(c1), 16'(c0)};
        cmp_we <= 3'h3;
        @(posedge clk);
        cmp_we <= 3'h0;
        run <= 1'b1;
        repeat (4) @(posedge clk);
        {chk_cnt, chk_cmp} = 2'h3;
        repeat (3 * (top + 1)) @(posedge clk);
        // Mid-period PWM write must wait for the next wrap
        for (k = 0; k < 100 && m_cnt != 2; k++) @(negedge clk);
        @(posedge clk);
        cmp_wdata[31:16] <= 16'(1 + $urandom % top);
        cmp_we <= 3'h2;
        @(posedge clk);
        cmp_we <= 3'h0;
        repeat (3 * (top + 1)) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        {chk_cnt, chk_cmp} = 2'h0;
        check("ovf_pulses", 16'(m_wraps), 16'(n_ovf));
        check("ovf_flag", 16'h1, {15'h0, ovf_flag});
        ovf_clear <= 1'b1;
        @(posedge clk);
        ovf_clear <= 1'b0;
        repeat (2) @(posedge clk);
        check("ovf_clr", 16'h0, {15'h0, ovf_flag});
        // Capture while counting: rising, falling, then ignored when off
        run <= 1'b1;
        for (k = 0; k < 3; k++) begin
            ch_mode[5:4] <= (k < 2) ? MODE_CAPTURE : MODE_OFF;
            cap_falling[2] <= k[0];
            src.cap_set(2, k != 1);
            check("cap_count", 16'((k < 2) ? k + 1 : 2), 16'(n_cap));
            check("cap_value", 16'(cap_exp), cap_seen);
            check("cap_trig", 16'((k < 2) ? k + 1 : 2), 16'(n_trig));
        end
        // External event counting
        n = 3 + $urandom % 5;
        top_value <= 16'hFFFF;
        count_events <= 1'b1;
        run <= 1'b1;
        repeat (n) src.ev_pulse();
        repeat (8) @(posedge clk);
        check("ev_count", 16'(m_cnt + n), count);
        run <= 1'b0;
        @(posedge clk);
        count_events <= 1'b0;
        // Dead time on the PWM pair
        dt = 2 + $urandom % 5;
        dt_cycles <= 8'(dt);
        dt_enable <= 1'b1;
        top_value <= 16'h0014;
        ch_mode[1:0] <= MODE_PWM;
        cmp_wdata[31:16] <= 16'h000A;
        cmp_we <= 3'h2;
        @(posedge clk);
        cmp_we <= 3'h0;
        run <= 1'b1;
        repeat (60) @(posedge clk);
        chk_dt = 1'b1;
        repeat (80) @(posedge clk);
        chk_dt = 1'b0;
        summarize();
    end
endmodule
